// file: verilog/sfp_front_end.sv
// serial flash pin front end: lane shifting, pause and hardware reset pin functions
//
// Design decisions made here: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps

// Behaviour
// - quad off, dedicated reset on: shared fourth pin is always pause.
// - quad off, dedicated reset off: select bit 0 gives pause, 1 gives reset.
// - pause low while selected floats the serial output.
// - pause freezes the transfer and keeps the partial sequence for resuming.
// - reset input low holds reset with outputs floating; high runs normally.
// - function bit 0 set disables the dedicated reset pin.
// - clock modes 0 and 3 both accepted, idle low or idle high.
// - sample on rising serial clock, drive from falling edge.
// - dual uses lanes zero and one; quad and four-lane command use all four with quad enable set, one lane without it.
// - quad enable makes the fourth pin a data lane only.
// - select high floats every output and ignores clock and lanes, except the fourth pin when it works as reset.
module sfp_front_end
    import sfp_pkg::*;
(
    // clock, reset, enable
    input  wire logic        ref_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // serial pins, bit 0 lane_zero up to bit 3 lane_three
    input  wire logic        sck_pin,
    input  wire logic        cs_n_pin,
    input  wire logic        ded_reset_n_pin,
    input  wire logic [3:0]  lane_in,
    output logic      [3:0]  lane_out,
    output logic      [3:0]  lane_oe
);

    typedef struct packed {
        sfp_state_type state;
        logic [4:0]    cfg;
        logic          func_dis;
        logic [7:0]    rx_sr;
        logic [7:0]    tx_sr;
        logic [3:0]    bit_cnt;
        logic          seen_rise;
        logic          reload;
        logic [7:0]    rx_data;
        logic [7:0]    tx_data;
        logic          rx_done;
        logic          ack;
        logic [31:0]   rdata;
    } sfp_core_state_type;

    sfp_core_state_type r_reg;
    sfp_core_state_type r_next;

    sfp_pin_if pins ();

    // ========================================
    // pin synchroniser
    sfp_pin_sync u_sync (
        .ref_clk         (ref_clk),
        .reset           (reset),
        .clk_en          (clk_en),
        .sck_pin         (sck_pin),
        .cs_n_pin        (cs_n_pin),
        .ded_reset_n_pin (ded_reset_n_pin),
        .lane_in         (lane_in),
        .pins            (pins.sync_side)
    );

    // ========================================
    // helpers
    function automatic logic [2:0] lane_width(input logic [1:0] mode, input logic qe);
        case (mode)
            SFP_LANE_DUAL:     return 3'h2;
            SFP_LANE_QUAD,
            SFP_LANE_FOUR_CMD: return qe ? 3'h4 : 3'h1;
            default:           return 3'h1;
        endcase
    endfunction : lane_width

    function automatic logic [7:0] shift_in(input logic [7:0] sr, input logic [3:0] ln,
                                            input logic [2:0] w);
        case (w)
            3'h2:    return {sr[5:0], ln[1:0]};
            3'h4:    return {sr[3:0], ln};
            default: return {sr[6:0], ln[0]};
        endcase
    endfunction : shift_in

    // ========================================
    // fourth pin function decode
    logic       qe;
    logic       fourth_is_reset;
    logic       fourth_is_pause;
    logic       ded_rst_act;
    logic       hw_rst_act;
    logic       pause_act;
    logic [2:0] width;
    logic       bus_req;
    logic [3:0] bit_sum;

    assign qe = r_reg.cfg[SFP_CFG_QE_BIT];
    assign fourth_is_reset = !qe && r_reg.func_dis && r_reg.cfg[SFP_CFG_SEL_BIT];
    assign fourth_is_pause = !qe && !fourth_is_reset;
    assign ded_rst_act     = !r_reg.func_dis && !pins.rst_n;
    assign hw_rst_act      = ded_rst_act || (fourth_is_reset && !pins.lanes[3]);
    assign pause_act       = fourth_is_pause && !pins.lanes[3] && !pins.cs_n;
    assign width           = lane_width(r_reg.cfg[SFP_CFG_MODE_LSB +: 2], qe);
    assign bus_req         = avs_read || avs_write;
    assign bit_sum         = r_reg.bit_cnt + {1'b0, width};

    // ========================================
    // next state: bus slave first, then the link, so a set beats a clear
    always_comb begin
        r_next     = r_reg;
        r_next.ack = bus_req && !r_reg.ack;
        // first request cycle latches read data, second cycle completes
        if (bus_req && !r_reg.ack) begin
            case (avs_address)
                SFP_OFS_CONFIG:   r_next.rdata = {27'h000_0000, r_reg.cfg};
                SFP_OFS_FUNCTION: r_next.rdata = {31'h0000_0000, r_reg.func_dis};
                SFP_OFS_STATUS:   r_next.rdata = {26'h000_0000, fourth_is_reset,
                                                  r_reg.state == SFP_ST_WAIT_SEL,
                                                  r_reg.state == SFP_ST_HW_RESET,
                                                  r_reg.state == SFP_ST_PAUSE,
                                                  !pins.cs_n, r_reg.rx_done};
                SFP_OFS_DATA:     r_next.rdata = {24'h00_0000, r_reg.rx_data};
                default:          r_next.rdata = 32'h0000_0000;
            endcase
        end
        // writes take effect on the cycle waitrequest is low
        if (avs_write && r_reg.ack && avs_byteenable[0]) begin
            case (avs_address)
                SFP_OFS_CONFIG:   r_next.cfg = avs_writedata[4:0];
                SFP_OFS_FUNCTION: r_next.func_dis = avs_writedata[SFP_FUNC_DIS_BIT];
                SFP_OFS_STATUS: begin
                    if (avs_writedata[SFP_ST_DONE_BIT]) begin
                        r_next.rx_done = 1'b0;
                    end
                end
                SFP_OFS_DATA:     r_next.tx_data = avs_writedata[7:0];
                default:          r_next.rx_done = r_next.rx_done;
            endcase
        end

        // link controller
        case (r_reg.state)
            SFP_ST_WAIT_SEL: begin
                if (pins.cs_fall) begin
                    r_next.state     = SFP_ST_SHIFT;
                    r_next.bit_cnt   = 4'h0;
                    r_next.rx_sr     = 8'h00;
                    r_next.tx_sr     = r_reg.tx_data;
                    r_next.seen_rise = 1'b0;
                    r_next.reload    = 1'b0;
                end
            end
            SFP_ST_SHIFT: begin
                if (pins.cs_n) begin
                    r_next.state = SFP_ST_WAIT_SEL;
                end else if (pause_act) begin
                    r_next.state = SFP_ST_PAUSE;
                end else if (pins.sck_rise) begin
                    r_next.rx_sr     = shift_in(r_reg.rx_sr, pins.lanes, width);
                    r_next.seen_rise = 1'b1;
                    r_next.bit_cnt   = bit_sum;
                    if (bit_sum >= SFP_BYTE_BITS) begin
                        r_next.rx_data = shift_in(r_reg.rx_sr, pins.lanes, width);
                        r_next.rx_done = 1'b1;
                        r_next.bit_cnt = 4'h0;
                        r_next.reload  = 1'b1;
                    end
                end else if (pins.sck_fall && r_reg.seen_rise) begin
                    r_next.tx_sr  = r_reg.reload ? r_reg.tx_data : 8'(r_reg.tx_sr << width);
                    r_next.reload = 1'b0;
                end
            end
            SFP_ST_PAUSE: begin
                if (pins.cs_n) begin
                    r_next.state = SFP_ST_WAIT_SEL;
                end else if (!pause_act) begin
                    r_next.state = SFP_ST_SHIFT;
                end
            end
            SFP_ST_HW_RESET: begin
                r_next.state = SFP_ST_WAIT_SEL;
            end
            default: begin
                r_next.state = SFP_ST_WAIT_SEL;
            end
        endcase

        if (hw_rst_act) begin
            r_next.state     = SFP_ST_HW_RESET;
            r_next.bit_cnt   = 4'h0;
            r_next.rx_sr     = 8'h00;
            r_next.seen_rise = 1'b0;
            r_next.reload    = 1'b0;
        end
    end

    // ========================================
    // state register, frozen while clock enable is low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r_reg <= '{state: SFP_ST_WAIT_SEL, cfg: SFP_CFG_RESET, func_dis: SFP_FUNC_RESET,
                       rx_sr: 8'h00, tx_sr: SFP_TX_RESET, bit_cnt: 4'h0, seen_rise: 1'b0,
                       reload: 1'b0, rx_data: 8'h00, tx_data: SFP_TX_RESET, rx_done: 1'b0,
                       ack: 1'b0, rdata: 32'h0000_0000};
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // ========================================
    // outputs
    assign avs_waitrequest = bus_req && !r_reg.ack;
    assign avs_readdata    = r_reg.rdata;

    always_comb begin
        lane_out = 4'h0;
        lane_oe  = 4'h0;
        case (width)
            3'h2:    lane_out[1:0] = r_reg.tx_sr[7:6];
            3'h4:    lane_out      = r_reg.tx_sr[7:4];
            default: lane_out[1]   = r_reg.tx_sr[7];
        endcase
        if (r_reg.state == SFP_ST_SHIFT && r_reg.cfg[SFP_CFG_DIR_BIT]) begin
            case (width)
                3'h2:    lane_oe = 4'h3;
                3'h4:    lane_oe = 4'hF;
                default: lane_oe = 4'h2;
            endcase
        end
    end

    // ========================================
    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    deselect_float_a: assert property (r_reg.state == SFP_ST_WAIT_SEL |-> lane_oe == 4'h0)
        else $error("lanes driven while deselected");
    pause_float_a: assert property (r_reg.state == SFP_ST_PAUSE |-> lane_oe == 4'h0)
        else $error("lanes driven during pause");
    pause_keep_a: assert property (r_reg.state == SFP_ST_PAUSE && !hw_rst_act |=> $stable(r_reg.rx_sr) && $stable(r_reg.bit_cnt))
        else $error("pause lost partial sequence");
    reset_enter_a: assert property (clk_en && hw_rst_act |=> r_reg.state == SFP_ST_HW_RESET && lane_oe == 4'h0)
        else $error("reset input not honoured");
    fresh_select_a: assert property (r_reg.state == SFP_ST_HW_RESET && clk_en && !hw_rst_act |=> r_reg.state == SFP_ST_WAIT_SEL)
        else $error("reset release skipped select wait");
    ded_pause_a: assert property (!qe && !r_reg.func_dis |-> fourth_is_pause && !fourth_is_reset)
        else $error("fourth pin not pause");
    select_map_a: assert property (!qe && r_reg.func_dis |-> fourth_is_reset == r_reg.cfg[SFP_CFG_SEL_BIT])
        else $error("pause or reset select ignored");
    quad_data_a: assert property (qe |-> !fourth_is_pause && !fourth_is_reset)
        else $error("quad lane still has pin function");
    ded_gate_a: assert property (r_reg.func_dis |-> !ded_rst_act)
        else $error("disabled dedicated reset acted");
    lead_fall_a: assert property (r_reg.state == SFP_ST_SHIFT && !r_reg.seen_rise && pins.sck_fall |=> $stable(r_reg.tx_sr))
        else $error("output shifted before first rise");
    rise_sample_a: assert property (r_reg.state == SFP_ST_SHIFT && clk_en && pins.sck_rise && !pins.cs_n && !pause_act && !hw_rst_act |=> r_reg.seen_rise)
        else $error("rising edge not sampled");

    byte_seen_c: cover property (r_reg.state == SFP_ST_SHIFT ##1 r_reg.rx_done);
    pause_resume_c: cover property (r_reg.state == SFP_ST_PAUSE ##1 r_reg.state == SFP_ST_SHIFT);
    hw_reset_c: cover property (r_reg.state == SFP_ST_HW_RESET ##1 r_reg.state == SFP_ST_WAIT_SEL);

endmodule : sfp_front_end

// file: verilog/sfp_pkg.sv
// shared constants and types of the serial flash pin front end
package sfp_pkg;

    // ========================================
    // register byte offsets
    localparam logic [3:0] SFP_OFS_CONFIG   = 4'h0;
    localparam logic [3:0] SFP_OFS_FUNCTION = 4'h4;
    localparam logic [3:0] SFP_OFS_STATUS   = 4'h8;
    localparam logic [3:0] SFP_OFS_DATA     = 4'hC;

    // ========================================
    // field positions
    localparam int SFP_CFG_QE_BIT   = 0;   // quad_lane_enable
    localparam int SFP_CFG_SEL_BIT  = 1;   // pause_or_reset_select
    localparam int SFP_CFG_MODE_LSB = 2;   // two bits of lane mode
    localparam int SFP_CFG_DIR_BIT  = 4;   // lanes drive outward
    localparam int SFP_FUNC_DIS_BIT = 0;   // dedicated reset disabled
    localparam int SFP_ST_DONE_BIT  = 0;   // byte received, write one to clear

    // ========================================
    // reset values and bits per byte
    localparam logic [4:0] SFP_CFG_RESET  = 5'h00;
    localparam logic       SFP_FUNC_RESET = 1'b0;
    localparam logic [7:0] SFP_TX_RESET   = 8'h00;
    localparam logic [6:0] SFP_PIN_IDLE   = 7'h60;  // reset pin and select high
    localparam logic [3:0] SFP_BYTE_BITS  = 4'h8;

    // ========================================
    // lane modes and controller states
    typedef enum logic [1:0] {
        SFP_LANE_SINGLE    = 2'h0,
        SFP_LANE_DUAL      = 2'h1,
        SFP_LANE_QUAD      = 2'h2,
        SFP_LANE_FOUR_CMD  = 2'h3
    } sfp_lane_mode_type;

    typedef enum logic [3:0] {
        SFP_ST_WAIT_SEL = 4'h1,
        SFP_ST_SHIFT    = 4'h2,
        SFP_ST_PAUSE    = 4'h4,
        SFP_ST_HW_RESET = 4'h8
    } sfp_state_type;

endpackage : sfp_pkg

// file: verilog/sfp_pin_if.sv
// synchronised pin levels and edge pulses between pin sync and core
`timescale 1ns/1ps
interface sfp_pin_if;
    logic       sck;
    logic       cs_n;
    logic       rst_n;
    logic [3:0] lanes;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;

    modport sync_side (output sck, cs_n, rst_n, lanes, sck_rise, sck_fall, cs_fall);
    modport core_side (input sck, cs_n, rst_n, lanes, sck_rise, sck_fall, cs_fall);
endinterface : sfp_pin_if

// file: verilog/sfp_pin_sync.sv
// two-stage synchroniser and edge finder for the serial pins
`timescale 1ns/1ps
module sfp_pin_sync
    import sfp_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       clk_en,
    // raw pins
    input  wire logic       sck_pin,
    input  wire logic       cs_n_pin,
    input  wire logic       ded_reset_n_pin,
    input  wire logic [3:0] lane_in,
    // synchronised side
    sfp_pin_if.sync_side    pins
);

    typedef struct packed {
        logic [6:0] meta;
        logic [6:0] sync;
        logic       sck_prev;
        logic       cs_prev;
    } sfp_sync_state_type;

    sfp_sync_state_type r_reg;
    sfp_sync_state_type r_next;

    // ========================================
    // next state: meta feeds only sync, edges come from later stages
    always_comb begin
        r_next          = r_reg;
        r_next.meta     = {ded_reset_n_pin, cs_n_pin, sck_pin, lane_in};
        r_next.sync     = r_reg.meta;
        r_next.sck_prev = r_reg.sync[4];
        r_next.cs_prev  = r_reg.sync[5];
    end

    // state register, frozen while clock enable is low
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            r_reg <= '{meta: SFP_PIN_IDLE, sync: SFP_PIN_IDLE, sck_prev: 1'b0, cs_prev: 1'b1};
        end else if (clk_en) begin
            r_reg <= r_next;
        end
    end

    // outputs toward the core
    assign pins.lanes    = r_reg.sync[3:0];
    assign pins.sck      = r_reg.sync[4];
    assign pins.cs_n     = r_reg.sync[5];
    assign pins.rst_n    = r_reg.sync[6];
    assign pins.sck_rise = clk_en & ~r_reg.sck_prev & r_reg.sync[4];
    assign pins.sck_fall = clk_en & r_reg.sck_prev & ~r_reg.sync[4];
    // a select that was already low at reset still gives one edge, as reset loads select high
    assign pins.cs_fall  = clk_en & r_reg.cs_prev & ~r_reg.sync[5];

endmodule : sfp_pin_sync

// file: test/sfp_spi_master.sv
// spi controller model: drives clock, select and lanes, captures returned bits
`timescale 1ns/1ps
module sfp_spi_master (
    // clock and pause request
    input  wire logic       ref_clk,
    input  wire logic       stall,
    // resolved lane levels
    input  wire logic [3:0] wire_l,
    // driven pins
    output logic            sck,
    output logic            cs_n,
    output logic [3:0]      lane,
    output logic [3:0]      oe
);
    logic [7:0] rx;
    // reset lines stay with the bench, so the hardware reset test can cut a reset into a write
    initial begin
        sck  = 1'b0;
        cs_n = 1'b1;
        lane = 4'h0;
        oe   = 4'h0;
        rx   = 8'h00;
    end
    // ========================================
    // one byte frame, w lanes per edge, m3 picks the idle-high clock
    task automatic xfer(input logic [7:0] tx, input int w, input logic m3, input logic drv);
        logic [7:0] sh;
        sh = tx;
        @(posedge ref_clk);
        // clock idles at the level of its mode
        sck <= m3;
        repeat (10) @(posedge ref_clk);
        cs_n <= 1'b0;
        // lane zero always driven in single, wider lanes only when sending
        oe <= (w == 1) ? 4'h1 : drv ? 4'((1 << w) - 1) : 4'h0;
        repeat (10) @(posedge ref_clk);
        sck <= 1'b0;
        for (int i = 0; i < 8; i += w) begin
            lane <= (w == 4) ? sh[7:4] : (w == 2) ? {2'h0, sh[7:6]} : {3'h0, sh[7]};
            sh = sh << w;
            repeat (10) @(posedge ref_clk);
            // returned bits are taken at the rising edge
            rx = (w == 4) ? {rx[3:0], wire_l} : (w == 2) ? {rx[5:0], wire_l[1:0]} : {rx[6:0], wire_l[1]};
            sck <= 1'b1;
            repeat (10) @(posedge ref_clk);
            // holding the clock high keeps a pause from eating a falling edge
            while (stall) @(posedge ref_clk);
            if (!(m3 && i + w >= 8)) sck <= 1'b0;
        end
        repeat (10) @(posedge ref_clk);
        cs_n <= 1'b1;
        oe   <= 4'h0;
    endtask : xfer
endmodule : sfp_spi_master

// file: test/sfp_front_end_tb.sv
// self-checking bench of the serial flash pin front end
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, ex, got); end end
module sfp_front_end_tb
    import sfp_pkg::*;
;
    // ========================================
    // clock, pins and bus
    logic        ref_clk, reset, avs_read, avs_write, avs_waitrequest;
    logic [3:0]  avs_address, lane_in, lane_out, lane_oe, wire_l, m_lane, m_oe;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic        sck, cs_n, ded_rst_n, fourth_lvl, stall;
    logic        flip = 1'b0;
    int          error_cnt, n_compared;

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    sfp_front_end DUT (.ref_clk(ref_clk), .reset(reset), .clk_en(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sck_pin(sck), .cs_n_pin(cs_n),
        .ded_reset_n_pin(ded_rst_n), .lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe));
    sfp_spi_master m (.ref_clk(ref_clk), .stall(stall), .wire_l(wire_l), .sck(sck), .cs_n(cs_n),
        .lane(m_lane), .oe(m_oe));

    // undriven lanes: pull-up on two, the bench level fourth_lvl on three, a toggling level on zero and one
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wire_l[i] = lane_oe[i] ? lane_out[i] : m_oe[i] ? m_lane[i] : (i == 3) ? fourth_lvl : ((i == 2) || flip);
        end
    end
    always @(posedge ref_clk) begin
        flip    <= ~flip;
        lane_in <= wire_l;
    end

    // ========================================
    // bus access: hold until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
        avs_address   <= a;
        avs_writedata <= {24'h00_0000, d};
        avs_read      <= ~wr;
        avs_write     <= wr;
        // no cycle count assumed: only the watchdog ends a hung wait
        do begin
            @(posedge ref_clk);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge ref_clk);
    endtask : bus

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 8'h00);
    endtask : rd

    task automatic t_regs;
        rd(SFP_OFS_FUNCTION);
        `CHK("function reset", 32'h0000_0000, q)
        bus(1'b1, 4'h3, 8'hFF);
        rd(4'h3);
        `CHK("unmapped read", 32'h0000_0000, q)
        rd(SFP_OFS_CONFIG);
        `CHK("config reset", 32'h0000_0000, q)
        $display("test regs done");
    endtask : t_regs

    task automatic t_single(input logic m3);
        bus(1'b1, SFP_OFS_CONFIG, 8'h10);
        bus(1'b1, SFP_OFS_DATA, 8'hA5);
        m.xfer(8'h3C, 1, m3, 1'b1);
        `CHK("controller rx", 8'hA5, m.rx)
        rd(SFP_OFS_DATA);
        `CHK("device rx", 8'h3C, q[7:0])
        rd(SFP_OFS_STATUS);
        `CHK("byte done", 1'b1, q[SFP_ST_DONE_BIT])
        `CHK("idle enables", 4'h0, lane_oe)
        bus(1'b1, SFP_OFS_STATUS, 8'h01);
        rd(SFP_OFS_STATUS);
        `CHK("done cleared", 1'b0, q[SFP_ST_DONE_BIT])
        $display("test single mode %0d done", m3 ? 3 : 0);
    endtask : t_single

    task automatic t_lanes;
        logic [7:0] dat;
        for (int j = 0; j < 4; j++) begin
            dat = 8'h5A ^ j[7:0];
            bus(1'b1, SFP_OFS_CONFIG, {3'h0, j[0], (j < 2) ? 2'h1 : {1'b1, j[0]}, 1'b0, j >= 2});
            bus(1'b1, SFP_OFS_DATA, dat);
            m.xfer(~dat, (j < 2) ? 2 : 4, 1'b0, ~j[0]);
            rd(SFP_OFS_DATA);
            if (j[0]) `CHK("lanes out", dat, m.rx)
            else `CHK("lanes in", ~dat, q[7:0])
        end
        $display("test lanes done");
    endtask : t_lanes

    // pause mid-byte, with dedicated reset on and then with select bit 0
    task automatic t_pause;
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, SFP_OFS_FUNCTION, k[7:0]);
            bus(1'b1, SFP_OFS_CONFIG, (k == 0) ? 8'h12 : 8'h10);
            bus(1'b1, SFP_OFS_DATA, 8'hC3);
            fork
                m.xfer(8'h81, 1, 1'b0, 1'b1);
                begin
                    repeat (74) @(posedge ref_clk);
                    stall      <= 1'b1;
                    fourth_lvl <= 1'b0;
                    repeat (8) @(posedge ref_clk);
                    `CHK("paused enables", 4'h0, lane_oe)
                    rd(SFP_OFS_STATUS);
                    `CHK("paused flag", 1'b1, q[2])
                    `CHK("selected flag", 1'b1, q[1])
                    fourth_lvl <= 1'b1;
                    repeat (6) @(posedge ref_clk);
                    stall <= 1'b0;
                end
            join
            `CHK("resumed rx", 8'hC3, m.rx)
            rd(SFP_OFS_DATA);
            `CHK("resumed device rx", 8'h81, q[7:0])
        end
        $display("test pause done");
    endtask : t_pause

    task automatic t_hwreset;
        bus(1'b1, SFP_OFS_FUNCTION, 8'h01);
        bus(1'b1, SFP_OFS_CONFIG, 8'h12);
        fork
            m.xfer(8'hFF, 1, 1'b0, 1'b1);
            begin
                repeat (74) @(posedge ref_clk);
                fourth_lvl <= 1'b0;
                repeat (8) @(posedge ref_clk);
                `CHK("reset enables", 4'h0, lane_oe)
                rd(SFP_OFS_STATUS);
                `CHK("reset flag", 1'b1, q[3])
                `CHK("fourth is reset", 1'b1, q[5])
                fourth_lvl <= 1'b1;
                repeat (8) @(posedge ref_clk);
                rd(SFP_OFS_STATUS);
                `CHK("wait for select", 1'b1, q[4])
            end
        join
        bus(1'b1, SFP_OFS_DATA, 8'h5C);
        m.xfer(8'hE7, 1, 1'b0, 1'b1);
        `CHK("fresh rx", 8'h5C, m.rx)
        rd(SFP_OFS_DATA);
        `CHK("fresh device rx", 8'hE7, q[7:0])
        ded_rst_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        rd(SFP_OFS_STATUS);
        `CHK("pin disabled", 1'b0, q[3])
        bus(1'b1, SFP_OFS_FUNCTION, 8'h00);
        repeat (4) @(posedge ref_clk);
        rd(SFP_OFS_STATUS);
        `CHK("pin enabled", 1'b1, q[3])
        ded_rst_n <= 1'b1;
        $display("test hardware reset done");
    endtask : t_hwreset

    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : results

    // ========================================
    // main sequence and watchdog
    initial begin
        {reset, ded_rst_n, fourth_lvl} = 3'h7;
        {avs_read, avs_write, stall} = 3'h0;
        avs_address   = 4'h0;
        avs_writedata = 32'h0000_0000;
        error_cnt     = 0;
        n_compared    = 0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_single(1'b0);
        t_single(1'b1);
        t_lanes();
        t_pause();
        t_hwreset();
        results();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        error_cnt++;
        results();
    end
endmodule : sfp_front_end_tb
